// ### rtl/terminal_regs_pkg.sv
// package: register map, field positions and reset values for the centre-terminal selector
package terminal_regs_pkg;
  // ==========================================================
  // register indices and byte addresses
  // ==========================================================
  localparam logic [7:0] AMP_A_LEAD_IDX = 8'h18; // first control register index
  localparam logic [7:0] AMP_BC_IDX = 8'h19; // second control register index
  localparam logic [11:0] AMP_A_LEAD_ADDR = 12'h060; // byte address, four times index
  localparam logic [11:0] AMP_BC_ADDR = 12'h064; // byte address, four times index
  // ==========================================================
  // field positions
  // ==========================================================
  localparam int AVG_CH4_BIT = 4; // amp b+c average to channel 4 negative
  localparam int A_POWER_BIT = 3; // amp a power on
  localparam int A_SEL_LSB = 0; // amp a select, 3 bits
  localparam int C_POWER_BIT = 7; // amp c power on
  localparam int B_POWER_BIT = 6; // amp b power on
  localparam int B_SEL_LSB = 3; // amp b select, 3 bits
  localparam int C_SEL_LSB = 0; // amp c select, 3 bits
  localparam int SEL_W = 3; // select field width
  localparam int INPUTS = 8; // electrode inputs of channels 1..4
  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic [4:0] AMP_A_LEAD_RST = 5'h00; // all off, channel 1 positive
  localparam logic [7:0] AMP_BC_RST = 8'h00; // all off, channel 1 positive
  localparam logic [2:0] SEL_RST = 3'h0; // channel 1 positive input
endpackage : terminal_regs_pkg

// ### rtl/electrode_select_decode.sv
// module: one-hot decode of a 3-bit electrode select code
`timescale 1ns/1ns
module electrode_select_decode (
  // select code
  input wire logic [2:0] select_code,
  // one switch per electrode: bit 2k is channel k+1 positive, bit 2k+1 negative
  output logic [7:0] switch_on
);
  // ==========================================================
  // decode
  // ==========================================================
  // upper bits are channel minus one, low bit picks the negative input
  genvar g;
  generate
    for (g = 0; g < terminal_regs_pkg::INPUTS; g++) begin : g_sw
      assign switch_on[g] = (select_code == 3'(g));
    end
  endgenerate
endmodule : electrode_select_decode

// ### rtl/center_terminal_select_regs.sv
// module: apb register bank steering the three centre-terminal averaging amplifiers
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
module center_terminal_select_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog controls
  output logic right_arm_avg_to_ch4_neg,
  output logic terminal_amp_a_power_on,
  output logic terminal_amp_b_power_on,
  output logic terminal_amp_c_power_on,
  output logic [2:0] terminal_amp_a_select,
  output logic [2:0] terminal_amp_b_select,
  output logic [2:0] terminal_amp_c_select,
  // electrode switch enables, one-hot per amplifier
  output logic [7:0] amp_a_switch_on,
  output logic [7:0] amp_b_switch_on,
  output logic [7:0] amp_c_switch_on
);
  // ==========================================================
  // storage
  // ==========================================================
  logic [4:0] lead_a_reg; // low five bits of first control register
  logic [7:0] bc_reg; // second control register
  logic hit_a; // address hits first register
  logic hit_bc; // address hits second register
  logic wr_fire; // write completes this edge
  logic rd_fire; // read completes this edge
  logic [31:0] prdata_next; // read mux

  // ==========================================================
  // address decode
  // ==========================================================
  // zero-wait slave: access phase always completes in one cycle
  assign pready = 1'b1;
  always_comb begin
    hit_a = 1'b0;
    hit_bc = 1'b0;
    if (paddr == terminal_regs_pkg::AMP_A_LEAD_ADDR) begin
      hit_a = 1'b1;
    end else if (paddr == terminal_regs_pkg::AMP_BC_ADDR) begin
      hit_bc = 1'b1;
    end
  end
  assign wr_fire = psel && penable && pwrite;
  assign rd_fire = psel && penable && !pwrite;
  // unmapped addresses report an error in the access phase
  assign pslverr = psel && penable && !hit_a && !hit_bc;

  // ==========================================================
  // first control register
  // ==========================================================
  // only byte lane 0 holds data; updates land on the completing edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lead_a_reg <= terminal_regs_pkg::AMP_A_LEAD_RST;
    end else if (wr_fire && hit_a && pstrb[0]) begin
      lead_a_reg <= pwdata[4:0];
    end
  end

  // ==========================================================
  // second control register
  // ==========================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bc_reg <= terminal_regs_pkg::AMP_BC_RST;
    end else if (wr_fire && hit_bc && pstrb[0]) begin
      bc_reg <= pwdata[7:0];
    end
  end

  // ==========================================================
  // read data
  // ==========================================================
  // upper bits of the first register belong elsewhere and read as zero here
  always_comb begin
    prdata_next = 32'h0000_0000;
    if (hit_a) begin
      prdata_next = {27'h0, lead_a_reg};
    end else if (hit_bc) begin
      prdata_next = {24'h000000, bc_reg};
    end
  end
  // read data registered on the setup cycle, valid in the access phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= prdata_next;
    end
  end

  // ==========================================================
  // field outputs
  // ==========================================================
  assign right_arm_avg_to_ch4_neg = lead_a_reg[terminal_regs_pkg::AVG_CH4_BIT];
  assign terminal_amp_a_power_on = lead_a_reg[terminal_regs_pkg::A_POWER_BIT];
  assign terminal_amp_c_power_on = bc_reg[terminal_regs_pkg::C_POWER_BIT];
  assign terminal_amp_b_power_on = bc_reg[terminal_regs_pkg::B_POWER_BIT];
  assign terminal_amp_a_select = lead_a_reg[terminal_regs_pkg::A_SEL_LSB +: 3];
  assign terminal_amp_b_select = bc_reg[terminal_regs_pkg::B_SEL_LSB +: 3];
  assign terminal_amp_c_select = bc_reg[terminal_regs_pkg::C_SEL_LSB +: 3];

  // ==========================================================
  // electrode switch decode
  // ==========================================================
  electrode_select_decode u_dec_a (
    .select_code(terminal_amp_a_select),
    .switch_on(amp_a_switch_on)
  );
  electrode_select_decode u_dec_b (
    .select_code(terminal_amp_b_select),
    .switch_on(amp_b_switch_on)
  );
  electrode_select_decode u_dec_c (
    .select_code(terminal_amp_c_select),
    .switch_on(amp_c_switch_on)
  );

  // ==========================================================
  // assertions
  // ==========================================================
  // a completed write with lane 0 enabled lands on the next edge;
  // $past looks back at the data that stood in the access phase
  ch4_avg_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_fire && hit_a && pstrb[0] |=> right_arm_avg_to_ch4_neg == $past(pwdata[4]))
    else $error("ch4 average enable did not follow write");
  // both power bits of the second register follow the write
  power_bits_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_fire && hit_bc && pstrb[0] |=> terminal_amp_c_power_on == $past(pwdata[7])
      && terminal_amp_b_power_on == $past(pwdata[6]))
    else $error("amp b/c power bits wrong after write");
  // amp a power bit follows the write
  a_power_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_fire && hit_a && pstrb[0] |=> terminal_amp_a_power_on == $past(pwdata[3]))
    else $error("amp a power bit wrong after write");
  // amp a select follows the write
  a_select_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_fire && hit_a && pstrb[0] |=> terminal_amp_a_select == $past(pwdata[2:0]))
    else $error("amp a select wrong after write");
  // amp b select follows the write
  b_select_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_fire && hit_bc && pstrb[0] |=> terminal_amp_b_select == $past(pwdata[5:3]))
    else $error("amp b select wrong after write");
  // amp c select follows the write
  c_select_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_fire && hit_bc && pstrb[0] |=> terminal_amp_c_select == $past(pwdata[2:0]))
    else $error("amp c select wrong after write");

  // ==========================================================
  // assertions: refused and unrelated transfers
  // ==========================================================
  // a write without lane 0 must not disturb the analog controls;
  // a stray strobe pattern would otherwise glitch the switches
  a_lane_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_fire && hit_a && !pstrb[0] |=> $stable(lead_a_reg))
    else $error("first register changed on gated write");
  // same gate on the second register
  bc_lane_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_fire && hit_bc && !pstrb[0] |=> $stable(bc_reg))
    else $error("second register changed on gated write");
  // unmapped writes are dropped; only the error response reports them,
  // so neither register may move
  unmapped_no_store_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_fire && !hit_a && !hit_bc |=> $stable(lead_a_reg) && $stable(bc_reg))
    else $error("register changed on unmapped write");
  // a write to the first register leaves the second alone
  a_keeps_bc_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_fire && hit_a |=> $stable(bc_reg))
    else $error("second register changed on first register write");
  // a write to the second register leaves the first alone
  bc_keeps_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_fire && hit_bc |=> $stable(lead_a_reg))
    else $error("first register changed on second register write");
  // without a write the stored fields hold, so the analog
  // switches never move on their own
  hold_no_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_fire |=> $stable(bc_reg) && $stable(lead_a_reg))
    else $error("register changed without a write");
  // reads have no side effect on the stored fields
  read_no_store_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_fire |=> $stable(bc_reg) && $stable(lead_a_reg))
    else $error("register changed on a read");

  // ==========================================================
  // assertions: electrode switch decode
  // ==========================================================
  // odd switch index is the negative input on amp a; exactly one switch
  // of amps b and c is closed so two electrodes are never shorted together
  decode_onehot_a: assert property (@(posedge clk) disable iff (!rst_n)
    amp_a_switch_on[{terminal_amp_a_select[2:1], 1'b1}] == terminal_amp_a_select[0]
      && $onehot(amp_b_switch_on) && $onehot(amp_c_switch_on))
    else $error("electrode switch decode wrong");
  // amp a closes the switch named by its code
  a_switch_match_a: assert property (@(posedge clk) disable iff (!rst_n)
    amp_a_switch_on == (8'h01 << terminal_amp_a_select))
    else $error("amp a switch does not match select");
  // amp b closes the switch named by its code
  b_switch_match_a: assert property (@(posedge clk) disable iff (!rst_n)
    amp_b_switch_on == (8'h01 << terminal_amp_b_select))
    else $error("amp b switch does not match select");
  // amp c closes the switch named by its code
  c_switch_match_a: assert property (@(posedge clk) disable iff (!rst_n)
    amp_c_switch_on == (8'h01 << terminal_amp_c_select))
    else $error("amp c switch does not match select");
  // the top code is channel 4 negative, the last switch;
  // channel 1 positive must be open then
  last_code_a: assert property (@(posedge clk) disable iff (!rst_n)
    terminal_amp_a_select == 3'h7 |-> amp_a_switch_on[7] && !amp_a_switch_on[0])
    else $error("top select code does not reach channel 4 negative");

  // ==========================================================
  // assertions: field outputs
  // ==========================================================
  // the average routing output is the stored bit
  ch4_avg_field_a: assert property (@(posedge clk) disable iff (!rst_n)
    right_arm_avg_to_ch4_neg == lead_a_reg[terminal_regs_pkg::AVG_CH4_BIT])
    else $error("ch4 average output differs from stored bit");
  // power outputs are the stored bits, one means powered on;
  // no inversion may creep in between register and pin
  power_fields_a: assert property (@(posedge clk) disable iff (!rst_n)
    terminal_amp_a_power_on == lead_a_reg[terminal_regs_pkg::A_POWER_BIT]
      && terminal_amp_c_power_on == bc_reg[terminal_regs_pkg::C_POWER_BIT]
      && terminal_amp_b_power_on == bc_reg[terminal_regs_pkg::B_POWER_BIT])
    else $error("power outputs differ from stored bits");
  // select outputs are the stored fields
  select_fields_a: assert property (@(posedge clk) disable iff (!rst_n)
    terminal_amp_a_select == lead_a_reg[2:0] && terminal_amp_b_select == bc_reg[5:3]
      && terminal_amp_c_select == bc_reg[2:0])
    else $error("select outputs differ from stored fields");

  // ==========================================================
  // assertions: bus responses
  // ==========================================================
  // the slave never inserts wait states, so a master
  // that waits for ready finishes in one access cycle
  ready_always_a: assert property (@(posedge clk) disable iff (!rst_n)
    psel && penable |-> pready)
    else $error("access phase was stretched");
  // the two register addresses never decode together
  hit_exclusive_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(hit_a && hit_bc))
    else $error("both registers decoded at once");
  // mapped registers answer without error
  mapped_no_error_a: assert property (@(posedge clk) disable iff (!rst_n)
    psel && penable && (hit_a || hit_bc) |-> !pslverr)
    else $error("error response on a mapped register");
  // the error response stands only in an access phase
  error_access_only_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(psel && penable) |-> !pslverr)
    else $error("error response outside an access phase");
  // the second register reads back as written, upper bits zero;
  // software relies on this to check the analog setup
  bc_readback_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_fire && hit_bc |-> prdata[7:0] == {terminal_amp_c_power_on, terminal_amp_b_power_on,
      terminal_amp_b_select, terminal_amp_c_select} && prdata[31:8] == 24'h0)
    else $error("second register readback wrong");
  // the first register reads back its low five bits only
  a_readback_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_fire && hit_a |-> prdata == {27'h0, right_arm_avg_to_ch4_neg, terminal_amp_a_power_on,
      terminal_amp_a_select})
    else $error("first register readback wrong");
  // unmapped reads return zero
  unmapped_read_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_fire && !hit_a && !hit_bc |-> prdata == 32'h0000_0000)
    else $error("unmapped read returned data");
  // read data only moves on a read setup cycle, so it stays
  // steady for the whole access phase
  prdata_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved outside a read setup");

  // ==========================================================
  // coverage of the main scenarios
  // ==========================================================
  // writes, reads, refused addresses and gated lanes
  write_a_c: cover property (@(posedge clk) disable iff (!rst_n) wr_fire && hit_a && pwdata[4]);
  write_bc_c: cover property (@(posedge clk) disable iff (!rst_n) wr_fire && hit_bc && pwdata[7:6] == 2'h3);
  read_bc_c: cover property (@(posedge clk) disable iff (!rst_n) rd_fire && hit_bc && prdata[7:0] != 8'h00);
  unmapped_c: cover property (@(posedge clk) disable iff (!rst_n) pslverr);
  gated_write_c: cover property (@(posedge clk) disable iff (!rst_n) wr_fire && (hit_a || hit_bc) && !pstrb[0]);
endmodule : center_terminal_select_regs

// ### dv/center_terminal_select_regs_test.sv
// testbench: apb register bank driving the centre-terminal amplifier controls
`timescale 1ns/1ns
module center_terminal_select_regs_test;
  // ==========================================================
  // stimulus and observed signals
  // ==========================================================
  logic clk = 1'b0; // 100 MHz clock
  logic rst_n = 1'b0; // active low reset
  logic psel = 1'b0; // apb select
  logic penable = 1'b0; // apb access phase
  logic pwrite = 1'b0; // apb direction
  logic [11:0] paddr = 12'h000; // byte address
  logic [31:0] pwdata = 32'h00000000; // write data
  logic [3:0] pstrb = 4'h0; // byte strobes
  logic [31:0] prdata; // read data
  logic pready, pslverr, avg_ch4, a_pwr, b_pwr, c_pwr; // answers and controls
  logic [2:0] a_sel, b_sel, c_sel; // select fields
  logic [7:0] a_sw, b_sw, c_sw; // switch enables
  int miscompares = 0; // mismatches seen
  int checked = 0; // comparisons made
  int cycles = 0; // timeout counter
  logic [31:0] rd; // read result
  logic err; // error response
  logic [7:0] v; // second register image
  always #5 clk = ~clk;
  center_terminal_select_regs u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .right_arm_avg_to_ch4_neg(avg_ch4), .terminal_amp_a_power_on(a_pwr), .terminal_amp_b_power_on(b_pwr),
    .terminal_amp_c_power_on(c_pwr), .terminal_amp_a_select(a_sel), .terminal_amp_b_select(b_sel),
    .terminal_amp_c_select(c_sel), .amp_a_switch_on(a_sw), .amp_b_switch_on(b_sw), .amp_c_switch_on(c_sw));
  // ==========================================================
  // shared tasks
  // ==========================================================
  // verdict and end of run
  task close_out;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  // one comparison
  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  // one apb transfer, held until pready is sampled high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // controls and switches against both register images
  task chk_out(input logic [7:0] r1, input logic [7:0] r2);
    @(negedge clk);
    cmp("controls", {19'h0, r1[4], r1[3], r2[6], r2[7], r1[2:0], r2[5:3], r2[2:0]},
      {19'h0, avg_ch4, a_pwr, b_pwr, c_pwr, a_sel, b_sel, c_sel});
    cmp("switches", {8'h00, 8'h01 << r1[2:0], 8'h01 << r2[5:3], 8'h01 << r2[2:0]}, {8'h00, a_sw, b_sw, c_sw});
  endtask : chk_out
  // ==========================================================
  // scenarios
  // ==========================================================
  // reset values of both registers
  task t_reset;
    chk_out(8'h00, 8'h00);
    apb(1'b0, 12'h060, 32'h0, 4'h0);
    cmp("first reg reset", 32'h0, rd);
    apb(1'b0, 12'h064, 32'h0, 4'h0);
    cmp("second reg reset", 32'h0, rd);
  endtask : t_reset
  // first register: only low five bits stored
  task t_first;
    apb(1'b1, 12'h060, 32'hFFFFFFFF, 4'hF);
    chk_out(8'h1F, 8'h00);
    apb(1'b0, 12'h060, 32'h0, 4'h0);
    cmp("first reg all ones", 32'h0000001F, rd);
    apb(1'b1, 12'h060, 32'h0000000A, 4'hF);
    chk_out(8'h0A, 8'h00);
  endtask : t_first
  // every select code on amps b and c, powers toggled
  task t_codes;
    for (int i = 0; i < 8; i++) begin
      v = {i[0], ~i[0], i[2:0], 3'(7 - i)};
      apb(1'b1, 12'h064, {24'h0, v}, 4'hF);
      chk_out(8'h0A, v);
      apb(1'b0, 12'h064, 32'h0, 4'h0);
      cmp("second reg readback", {24'h0, v}, rd);
      cmp("second reg error", 32'h0, {31'h0, err});
    end
  endtask : t_codes
  // unmapped address and gated write leave state alone
  task t_refuse;
    apb(1'b1, 12'h068, 32'h000000FF, 4'hF);
    cmp("unmapped write error", 32'h1, {31'h0, err});
    apb(1'b0, 12'h068, 32'h0, 4'h0);
    cmp("unmapped read data", 32'h0, rd);
    cmp("unmapped read error", 32'h1, {31'h0, err});
    apb(1'b1, 12'h064, 32'h00000000, 4'hE);
    chk_out(8'h0A, v);
  endtask : t_refuse
  // ==========================================================
  // timeout and main sequence
  // ==========================================================
  // cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      close_out;
    end
  end
  // reset, then each scenario in turn
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_first;
    t_codes;
    t_refuse;
    close_out;
  end
endmodule : center_terminal_select_regs_test
